//--- src/ebc_cfg_top.sv
//
// Overview of operation
// - Each area's access-state bit picks two- or three-state access, 1 meaning three-state.
// - A three-bit wait field per area sets the program wait cycles, 111 giving seven.
// - With SDRAM on area 2 its wait field is the CAS latency and its top bit is ignored.
// - With SDRAM, 01 in the low two bits of the area 2 wait field gives CAS latency two.
// - Bits 15 to 12 of the idle register set idle cycle insertion, 0 inserting none.
// - Each area's byte-order bit selects endianness, 0 meaning big-endian.
// - Each area's interface bit picks basic bus at 0 or byte-control SRAM at 1.
// - Bit 15 of the DRAM control register at 1 makes area 2 a DRAM/SDRAM interface.
// - Bit 14 picks the DRAM kind on area 2, 1 meaning SDRAM.
// - Bit 11 at 1 enables the shared pin as EDO output enable or SDRAM clock enable.
// - Bit 7 at 1 lets the DRAM or SDRAM be accessed in high-speed page mode.
// - A two-bit precharge field sets RAS precharge cycles, 00 giving one cycle.
// - A two-bit RAS-to-CAS field sets waits between RAS and CAS, 00 giving none.
// - Bit 15 of the SDRAM control register at 1 permits mode register setting.
// - A byte write to SDRAM space then programs the mode; software clears the bit after.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ebc_cfg_top (
  // APB clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Mode register write from the bus controller
  input  wire logic                sdram_byte_wr,
  input  wire logic [15:0]         sdram_wr_addr,
  // Area setups
  output ebc_pkg::ebc_area_cfg_t   area2_cfg,
  output ebc_pkg::ebc_area_cfg_t   area4_cfg,
  output ebc_pkg::ebc_dram_cfg_t   dram_cfg,
  output logic [ebc_pkg::IDLE_W-1:0] idle_insert_field,
  output logic                     idle_insert_en,
  // SDRAM mode command
  output logic                     mrs_cmd,
  output logic [15:0]              mrs_value
);
  import ebc_pkg::*;

  // ***************************************************
  // Address decode
  // ***************************************************

  // Maps a byte address to a register index; used by read and write
  function automatic logic [IDX_W:0] addr_decode(
    input logic [31:0] adr
  );
    logic [OFS_W-1:0] ofs;
    logic             ok;
    ofs = adr[ADR_LSB+OFS_W-1:ADR_LSB];
    ok  = (adr[31:ADR_LSB+OFS_W] == '0) && (adr[ADR_LSB-1:0] == '0);
    addr_decode = '0;
    if (ok) begin
      case (ofs)
        OFS_ACCESS_STATE: addr_decode = {1'b1, RI_ACCESS_STATE};
        OFS_WAIT_A:       addr_decode = {1'b1, RI_WAIT_A};
        OFS_WAIT_B:       addr_decode = {1'b1, RI_WAIT_B};
        OFS_IDLE:         addr_decode = {1'b1, RI_IDLE};
        OFS_BYTE_ORDER:   addr_decode = {1'b1, RI_BYTE_ORDER};
        OFS_SRAM_IF:      addr_decode = {1'b1, RI_SRAM_IF};
        OFS_DRAM_IF:      addr_decode = {1'b1, RI_DRAM_IF};
        OFS_DRAM_TIM:     addr_decode = {1'b1, RI_DRAM_TIM};
        OFS_SDRAM:        addr_decode = {1'b1, RI_SDRAM};
        OFS_STATUS:       addr_decode = {1'b1, RI_STATUS};
        default:          addr_decode = '0;
      endcase
    end
  endfunction

  // Writable-bit mask of a register index
  function automatic logic [DATA_W-1:0] reg_mask(
    input logic [IDX_W-1:0] idx
  );
    case (idx)
      RI_ACCESS_STATE: reg_mask = MASK_ACCESS_STATE;
      RI_WAIT_A:       reg_mask = MASK_WAIT_A;
      RI_WAIT_B:       reg_mask = MASK_WAIT_B;
      RI_IDLE:         reg_mask = MASK_IDLE;
      RI_BYTE_ORDER:   reg_mask = MASK_BYTE_ORDER;
      RI_SRAM_IF:      reg_mask = MASK_SRAM_IF;
      RI_DRAM_IF:      reg_mask = MASK_DRAM_IF;
      RI_DRAM_TIM:     reg_mask = MASK_DRAM_TIM;
      RI_SDRAM:        reg_mask = MASK_SDRAM;
      default:         reg_mask = '0;
    endcase
  endfunction

  logic [IDX_W:0]   dec;
  logic             hit;
  logic [IDX_W-1:0] idx;
  logic             wr_acc;
  logic             rd_acc;

  // Zero-wait slave: every access completes in its first access cycle
  assign dec    = addr_decode(paddr);
  assign hit    = dec[IDX_W];
  assign idx    = dec[IDX_W-1:0];
  assign wr_acc = psel && penable && pwrite && hit;
  assign rd_acc = psel && penable && !pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ***************************************************
  // Register storage
  // ***************************************************
  logic [DATA_W-1:0] regs_ff     [NUM_REGS-1];
  logic [DATA_W-1:0] nxt_regs    [NUM_REGS-1];
  logic              done_ff;
  logic              nxt_done;
  logic              confl;
  logic              mrs_done;

  // Plain stores of the configuration registers
  always_comb begin
    for (int i = 0; i < NUM_REGS-1; i++) begin
      nxt_regs[i] = regs_ff[i];
      if (wr_acc && (idx == i[IDX_W-1:0])) begin
        nxt_regs[i] = pwdata[DATA_W-1:0] & reg_mask(i[IDX_W-1:0]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_REGS-1; i++) begin
        regs_ff[i] <= REG_RST;
      end
    end else begin
      for (int i = 0; i < NUM_REGS-1; i++) begin
        regs_ff[i] <= nxt_regs[i];
      end
    end
  end

  // Mode-set done flag: write 1 clears, a new completion wins the cycle
  always_comb begin
    nxt_done = done_ff;
    if (wr_acc && (idx == RI_STATUS) && pwdata[ST_DONE]) begin
      nxt_done = 1'b0;
    end
    if (mrs_done) begin
      nxt_done = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;
    end
  end

  // ***************************************************
  // Read data
  // ***************************************************
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  // Captured at the setup cycle so it is stable in the access cycle
  always_comb begin
    nxt_rdata = rdata_ff;
    if (psel && !penable && !pwrite) begin
      nxt_rdata = '0;
      if (hit && (idx == RI_STATUS)) begin
        nxt_rdata[ST_DONE]  = done_ff;
        nxt_rdata[ST_CONFL] = confl;
      end else if (hit) begin
        nxt_rdata[DATA_W-1:0] = regs_ff[idx];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign prdata = rd_acc ? rdata_ff : '0;

  // ***************************************************
  // Field extraction
  // ***************************************************
  logic [DATA_W-1:0] r_ast;
  logic [DATA_W-1:0] r_wa;
  logic [DATA_W-1:0] r_wb;
  logic [DATA_W-1:0] r_idle;
  logic [DATA_W-1:0] r_le;
  logic [DATA_W-1:0] r_sram;
  logic [DATA_W-1:0] r_dram;
  logic [DATA_W-1:0] r_tim;
  logic [DATA_W-1:0] r_sd;

  assign r_ast  = regs_ff[RI_ACCESS_STATE];
  assign r_wa   = regs_ff[RI_WAIT_A];
  assign r_wb   = regs_ff[RI_WAIT_B];
  assign r_idle = regs_ff[RI_IDLE];
  assign r_le   = regs_ff[RI_BYTE_ORDER];
  assign r_sram = regs_ff[RI_SRAM_IF];
  assign r_dram = regs_ff[RI_DRAM_IF];
  assign r_tim  = regs_ff[RI_DRAM_TIM];
  assign r_sd   = regs_ff[RI_SDRAM];

  logic sdram_on;

  // SDRAM mode needs the DRAM interface and the SDRAM kind together
  assign sdram_on = r_dram[AREA2_DRAM_IFACE_SEL_BIT] && r_dram[KIND_BIT];

  // Software must not leave area 2 byte-control with DRAM enabled
  assign confl = r_dram[AREA2_DRAM_IFACE_SEL_BIT] && r_sram[BC2_BIT];

  // ***************************************************
  // Per-area setup
  // ***************************************************
  logic [NUM_AREAS-1:0] a_ast;
  logic [NUM_AREAS-1:0] a_le;
  logic [NUM_AREAS-1:0] a_bc;
  logic [NUM_AREAS-1:0] a_cas;
  logic [WAIT_W-1:0]    a_wait [NUM_AREAS];
  ebc_area_cfg_t        a_cfg  [NUM_AREAS];

  // Index 0 is area 2, index 1 is area 4
  assign a_ast   = {r_ast[AREA4_THREE_STATE_SEL_BIT], r_ast[AREA2_THREE_STATE_SEL_BIT]};
  assign a_le    = {r_le[LE4_BIT], r_le[LE2_BIT]};
  assign a_bc    = {r_sram[BC4_BIT], r_sram[BC2_BIT]};
  assign a_cas   = {1'b0, sdram_on};
  assign a_wait[0] = r_wb[WAITB_LSB +: WAIT_W];
  assign a_wait[1] = r_wa[WAITA_LSB +: WAIT_W];

  generate
    for (genvar g = 0; g < NUM_AREAS; g++) begin : g_area
      ebc_area_cfg u_area (
        .pclk               (pclk),
        .presetn            (presetn),
        .three_state_sel    (a_ast[g]),
        .wait_field         (a_wait[g]),
        .little_endian      (a_le[g]),
        .byte_ctrl_sram_sel (a_bc[g]),
        .cas_mode           (a_cas[g]),
        .cfg                (a_cfg[g])
      );
    end
  endgenerate

  assign area2_cfg = a_cfg[0];
  assign area4_cfg = a_cfg[1];

  // ***************************************************
  // DRAM setup
  // ***************************************************
  ebc_dram_cfg_t dram_ff;
  ebc_dram_cfg_t nxt_dram;
  logic [IDLE_W-1:0] idle_ff;
  logic [IDLE_W-1:0] nxt_idle;
  logic [CAS_W-1:0]  cas_code;
  logic [TPC_W-1:0]  tpc_code;

  // Top wait bit is dropped: only two bits code the latency
  assign cas_code = r_wb[WAITB_LSB +: CAS_W];
  assign tpc_code = r_tim[TPC_LSB +: TPC_W];

  // Decode of area 2 memory timing and pin enables
  always_comb begin
    nxt_dram.dram_sel     = r_dram[AREA2_DRAM_IFACE_SEL_BIT];
    nxt_dram.sdram        = sdram_on;
    nxt_dram.edo_oe_en    = r_dram[AREA2_DRAM_IFACE_SEL_BIT] && !r_dram[KIND_BIT]
                            && r_dram[OUTEN_BIT];
    nxt_dram.sdram_cke_en = sdram_on && r_dram[OUTEN_BIT];
    nxt_dram.burst_en     = r_dram[AREA2_DRAM_IFACE_SEL_BIT] && r_dram[BURST_BIT];
    // Code 00 means one cycle, so count is code plus one
    nxt_dram.precharge_cycles = {1'b0, tpc_code} + 3'h1;
    nxt_dram.row_col_waits    = r_tim[RCD_LSB +: RCD_W];
    // Code 01 means latency two, so latency is code plus one
    nxt_dram.cas_latency = sdram_on ?
      ({1'b0, cas_code} + 3'h1) : 3'h0;
    nxt_dram.mode_reg_set_enable = sdram_on && r_sd[MODE_REG_SET_ENABLE_BIT];
    nxt_idle = r_idle[IDLE_LSB +: IDLE_W];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dram_ff <= '0;
      idle_ff <= '0;
    end else begin
      dram_ff <= nxt_dram;
      idle_ff <= nxt_idle;
    end
  end

  assign dram_cfg          = dram_ff;
  assign idle_insert_field = idle_ff;
  assign idle_insert_en    = (idle_ff != '0);

  // ***************************************************
  // SDRAM mode register programming
  // ***************************************************
  ebc_mrs_ctrl u_mrs (
    .pclk          (pclk),
    .presetn       (presetn),
    .mrs_allowed   (dram_ff.mode_reg_set_enable),
    .sdram_byte_wr (sdram_byte_wr),
    .sdram_wr_addr (sdram_wr_addr),
    .mrs_cmd       (mrs_cmd),
    .mrs_value     (mrs_value),
    .mrs_done      (mrs_done)
  );

endmodule
`default_nettype wire

//--- src/ebc_pkg.sv
package ebc_pkg;

  // ***************************************************
  // Register map
  // ***************************************************
  localparam int unsigned NUM_REGS = 10;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned IDX_W    = 4;
  localparam int unsigned OFS_W    = 24;
  localparam int unsigned ADR_LSB  = 2;

  // Offsets are word indices; byte address is index times four
  localparam logic [OFS_W-1:0] OFS_ACCESS_STATE = 24'hfffd86;
  localparam logic [OFS_W-1:0] OFS_WAIT_A       = 24'hfffd88;
  localparam logic [OFS_W-1:0] OFS_WAIT_B       = 24'hfffd8a;
  localparam logic [OFS_W-1:0] OFS_IDLE         = 24'hfffd90;
  localparam logic [OFS_W-1:0] OFS_BYTE_ORDER   = 24'hfffd95;
  localparam logic [OFS_W-1:0] OFS_SRAM_IF      = 24'hfffd98;
  localparam logic [OFS_W-1:0] OFS_DRAM_IF      = 24'hfffda0;
  localparam logic [OFS_W-1:0] OFS_DRAM_TIM     = 24'hfffda2;
  localparam logic [OFS_W-1:0] OFS_SDRAM        = 24'hfffda4;
  localparam logic [OFS_W-1:0] OFS_STATUS       = 24'hfffdbe;

  typedef enum logic [IDX_W-1:0] {
    RI_ACCESS_STATE = 4'h0,
    RI_WAIT_A       = 4'h1,
    RI_WAIT_B       = 4'h2,
    RI_IDLE         = 4'h3,
    RI_BYTE_ORDER   = 4'h4,
    RI_SRAM_IF      = 4'h5,
    RI_DRAM_IF      = 4'h6,
    RI_DRAM_TIM     = 4'h7,
    RI_SDRAM        = 4'h8,
    RI_STATUS       = 4'h9
  } ebc_reg_idx_t;

  // Writable bits per register; all others read as zero
  localparam logic [DATA_W-1:0] MASK_ACCESS_STATE = 16'h1400;
  localparam logic [DATA_W-1:0] MASK_WAIT_A       = 16'h0007;
  localparam logic [DATA_W-1:0] MASK_WAIT_B       = 16'h0700;
  localparam logic [DATA_W-1:0] MASK_IDLE         = 16'hf000;
  localparam logic [DATA_W-1:0] MASK_BYTE_ORDER   = 16'h0014;
  localparam logic [DATA_W-1:0] MASK_SRAM_IF      = 16'h1400;
  localparam logic [DATA_W-1:0] MASK_DRAM_IF      = 16'hc880;
  localparam logic [DATA_W-1:0] MASK_DRAM_TIM     = 16'h3300;
  localparam logic [DATA_W-1:0] MASK_SDRAM        = 16'h8000;
  localparam logic [DATA_W-1:0] REG_RST           = 16'h0000;

  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int unsigned AREA4_THREE_STATE_SEL_BIT  = 12;
  localparam int unsigned AREA2_THREE_STATE_SEL_BIT  = 10;
  localparam int unsigned WAIT_W    = 3;
  localparam int unsigned WAITA_LSB = 0;
  localparam int unsigned WAITB_LSB = 8;
  localparam int unsigned IDLE_W    = 4;
  localparam int unsigned IDLE_LSB  = 12;
  localparam int unsigned LE4_BIT   = 4;
  localparam int unsigned LE2_BIT   = 2;
  localparam int unsigned BC4_BIT   = 12;
  localparam int unsigned BC2_BIT   = 10;
  localparam int unsigned AREA2_DRAM_IFACE_SEL_BIT = 15;
  localparam int unsigned KIND_BIT  = 14;
  localparam int unsigned OUTEN_BIT = 11;
  localparam int unsigned BURST_BIT = 7;
  localparam int unsigned TPC_W     = 2;
  localparam int unsigned TPC_LSB   = 12;
  localparam int unsigned RCD_W     = 2;
  localparam int unsigned RCD_LSB   = 8;
  localparam int unsigned MODE_REG_SET_ENABLE_BIT  = 15;
  localparam int unsigned CAS_W     = 2;
  localparam int unsigned ST_DONE   = 0;
  localparam int unsigned ST_CONFL  = 1;
  localparam int unsigned NUM_AREAS = 2;

  // ***************************************************
  // Carriers
  // ***************************************************
  typedef struct packed {
    logic              three_state;
    logic [WAIT_W-1:0] wait_cycles;
    logic              little_endian;
    logic              byte_ctrl_sram;
  } ebc_area_cfg_t;

  typedef struct packed {
    logic               dram_sel;
    logic               sdram;
    logic               edo_oe_en;
    logic               sdram_cke_en;
    logic               burst_en;
    logic [TPC_W:0]     precharge_cycles;
    logic [RCD_W-1:0]   row_col_waits;
    logic [CAS_W:0]     cas_latency;
    logic               mode_reg_set_enable;
  } ebc_dram_cfg_t;

  typedef enum logic [1:0] {
    MRS_IDLE     = 2'b00,
    MRS_ARMED    = 2'b01,
    MRS_ISSUE    = 2'b10,
    MRS_WAIT_CLR = 2'b11
  } ebc_mrs_state_t;

endpackage

//--- src/ebc_area_cfg.sv
`timescale 1ns/100ps
`default_nettype none
module ebc_area_cfg (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Raw register bits
  input  wire logic                  three_state_sel,
  input  wire logic [ebc_pkg::WAIT_W-1:0] wait_field,
  input  wire logic                  little_endian,
  input  wire logic                  byte_ctrl_sram_sel,
  input  wire logic                  cas_mode,
  // Decoded area setup
  output ebc_pkg::ebc_area_cfg_t     cfg
);
  import ebc_pkg::*;

  ebc_area_cfg_t cfg_ff;
  ebc_area_cfg_t nxt_cfg;

  // Decode; in CAS mode the field holds latency, not program waits
  always_comb begin
    nxt_cfg.three_state    = three_state_sel;
    nxt_cfg.wait_cycles    = cas_mode ? '0 : wait_field;
    nxt_cfg.little_endian  = little_endian;
    nxt_cfg.byte_ctrl_sram = byte_ctrl_sram_sel;
  end

  // Registered so the bus controller sees a stable setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  assign cfg = cfg_ff;

endmodule
`default_nettype wire

//--- src/ebc_mrs_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module ebc_mrs_ctrl (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control
  input  wire logic        mrs_allowed,
  input  wire logic        sdram_byte_wr,
  input  wire logic [15:0] sdram_wr_addr,
  // Command
  output logic             mrs_cmd,
  output logic [15:0]      mrs_value,
  output logic             mrs_done
);
  import ebc_pkg::*;

  ebc_mrs_state_t state_ff;
  ebc_mrs_state_t nxt_state;
  logic [15:0]    value_ff;
  logic [15:0]    nxt_value;

  // One mode program per enable session; software must clear to rearm
  always_comb begin
    nxt_state = state_ff;
    nxt_value = value_ff;
    case (state_ff)
      MRS_IDLE: begin
        if (mrs_allowed) nxt_state = MRS_ARMED;
      end
      MRS_ARMED: begin
        if (!mrs_allowed) begin
          nxt_state = MRS_IDLE;
        end else if (sdram_byte_wr) begin
          nxt_state = MRS_ISSUE;
          nxt_value = sdram_wr_addr;
        end
      end
      MRS_ISSUE: nxt_state = MRS_WAIT_CLR;
      MRS_WAIT_CLR: begin
        if (!mrs_allowed) nxt_state = MRS_IDLE;
      end
      default: nxt_state = MRS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= MRS_IDLE;
      value_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      value_ff <= nxt_value;
    end
  end

  assign mrs_cmd   = (state_ff == MRS_ISSUE);
  assign mrs_done  = (state_ff == MRS_ISSUE);
  assign mrs_value = value_ff;

endmodule
`default_nettype wire

//--- tb/ebc_cfg_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ebc_cfg_sva (
  // Clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // Bus error and mode write
  input wire logic                   pslverr,
  input wire logic                   sdram_byte_wr,
  input wire logic [15:0]            sdram_wr_addr,
  // Decoded setups
  input wire ebc_pkg::ebc_area_cfg_t area2_cfg,
  input wire ebc_pkg::ebc_dram_cfg_t dram_cfg,
  input wire logic [3:0]             idle_insert_field,
  input wire logic                   idle_insert_en,
  // Mode command
  input wire logic                   mrs_cmd,
  input wire logic [15:0]            mrs_value
);
  import ebc_pkg::*;
  // ***************************************************
  // Properties
  // ***************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_mrs_pulse: assert property (mrs_cmd |=> !mrs_cmd)
    else $error("mode command longer than one cycle");
  chk_mrs_cause: assert property (mrs_cmd |-> $past(sdram_byte_wr))
    else $error("mode command without byte write");
  chk_mrs_value: assert property (
    mrs_cmd |-> mrs_value == $past(sdram_wr_addr))
    else $error("mode value not the written address");
  chk_mrs_gate: assert property (
    sdram_byte_wr && !dram_cfg.mode_reg_set_enable &&
    !$past(dram_cfg.mode_reg_set_enable) |=> !mrs_cmd)
    else $error("mode command while setting disabled");
  // Value may only move together with a command
  chk_mrs_hold: assert property ($changed(mrs_value) |-> mrs_cmd)
    else $error("mode value changed without command");
  chk_sdram_wait: assert property (
    dram_cfg.dram_sel && dram_cfg.sdram |-> area2_cfg.wait_cycles == 3'h0)
    else $error("area 2 waits used as program waits with SDRAM");
  chk_cas_range: assert property (
    dram_cfg.dram_sel && dram_cfg.sdram |-> dram_cfg.cas_latency inside
    {[3'h1:3'h4]})
    else $error("CAS latency out of range");
  chk_idle_en: assert property (
    idle_insert_en == (idle_insert_field != 4'h0))
    else $error("idle enable does not follow field");
  chk_dram_gate: assert property (!dram_cfg.dram_sel |->
    !dram_cfg.burst_en && !dram_cfg.edo_oe_en && !dram_cfg.sdram_cke_en)
    else $error("DRAM feature active while area 2 not DRAM");
  chk_oe_cke: assert property (
    !(dram_cfg.edo_oe_en && dram_cfg.sdram_cke_en))
    else $error("shared pin enabled for both uses");
  // Previous cycle check skips the edge right after reset release
  chk_precharge: assert property (
    $past(presetn) |-> dram_cfg.precharge_cycles != 3'h0)
    else $error("zero precharge cycles");
  cov_mrs: cover property (mrs_cmd);
  cov_err: cover property (pslverr);
  cov_sdram: cover property (dram_cfg.dram_sel && dram_cfg.sdram);
endmodule
bind ebc_cfg_top ebc_cfg_sva u_sva (.pclk(pclk), .presetn(presetn),
  .pslverr(pslverr), .sdram_byte_wr(sdram_byte_wr),
  .sdram_wr_addr(sdram_wr_addr), .area2_cfg(area2_cfg),
  .dram_cfg(dram_cfg), .idle_insert_field(idle_insert_field),
  .idle_insert_en(idle_insert_en), .mrs_cmd(mrs_cmd),
  .mrs_value(mrs_value));
`default_nettype wire

//--- tb/ebc_sdram_model.sv
`timescale 1ns/100ps
`default_nettype none
module ebc_sdram_model (
  // Clock
  input  wire logic        pclk,
  // Mode command from the controller
  input  wire logic        mrs_cmd,
  input  wire logic [15:0] mrs_value,
  // Observed memory state
  output logic [15:0]      mode_q,
  output logic [7:0]       mrs_cnt
);
  logic [15:0] mode_ff = 16'h0000;
  logic [7:0]  cnt_ff  = 8'h00;
  // Memory latches its mode on each command; count shows repeats
  always @(posedge pclk) begin
    if (mrs_cmd) begin
      mode_ff <= mrs_value;
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  assign mode_q  = mode_ff;
  assign mrs_cnt = cnt_ff;
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ebc_pkg::*;
  // ***************************************************
  // Signals and tables
  // ***************************************************
  typedef struct packed {logic [3:0] idx; logic [15:0] wd;} ebc_row_t;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic sdram_byte_wr, mrs_cmd, idle_insert_en, rd_err;
  logic [31:0] paddr, pwdata, prdata, rd_data;
  logic [15:0] sdram_wr_addr, mrs_value, mode_q;
  logic [3:0]  idle_insert_field;
  logic [7:0]  mrs_cnt;
  logic [15:0] shadow [NUM_REGS];
  ebc_area_cfg_t area2_cfg, area4_cfg;
  ebc_dram_cfg_t dram_cfg;
  int error_cnt, tests_run;
  localparam logic [OFS_W-1:0] OFS_TAB [NUM_REGS] = '{OFS_ACCESS_STATE,
    OFS_WAIT_A, OFS_WAIT_B, OFS_IDLE, OFS_BYTE_ORDER, OFS_SRAM_IF,
    OFS_DRAM_IF, OFS_DRAM_TIM, OFS_SDRAM, OFS_STATUS};
  localparam logic [15:0] MSK [NUM_REGS] = '{MASK_ACCESS_STATE,
    MASK_WAIT_A, MASK_WAIT_B, MASK_IDLE, MASK_BYTE_ORDER, MASK_SRAM_IF,
    MASK_DRAM_IF, MASK_DRAM_TIM, MASK_SDRAM, 16'h0000};
  // Order matters: SDRAM is only turned on once the waits are set
  localparam ebc_row_t ROWS [13] = '{'{4'h0, 16'hffff},
    '{4'h1, 16'hffff}, '{4'h2, 16'h0100}, '{4'h3, 16'hf000},
    '{4'h3, 16'h0000}, '{4'h4, 16'h00ff}, '{4'h5, 16'h1000},
    '{4'h6, 16'h8880}, '{4'h7, 16'h3300}, '{4'h7, 16'h0000},
    '{4'h6, 16'hc800}, '{4'h2, 16'h0500}, '{4'h4, 16'h0010}};
  // ***************************************************
  // Design and memory model
  // ***************************************************
  ebc_cfg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sdram_byte_wr(sdram_byte_wr), .sdram_wr_addr(sdram_wr_addr),
    .area2_cfg(area2_cfg), .area4_cfg(area4_cfg), .dram_cfg(dram_cfg),
    .idle_insert_field(idle_insert_field),
    .idle_insert_en(idle_insert_en), .mrs_cmd(mrs_cmd),
    .mrs_value(mrs_value));
  ebc_sdram_model u_mem (.pclk(pclk), .mrs_cmd(mrs_cmd),
    .mrs_value(mrs_value), .mode_q(mode_q), .mrs_cnt(mrs_cnt));
  always #20 pclk = ~pclk;
  // ***************************************************
  // Tasks
  // ***************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen high at an edge
  task apb(input logic wr, input logic [OFS_W-1:0] ofs,
           input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {6'h00, ofs, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task reg_wr(input int i, input logic [15:0] wd);
    apb(1'b1, OFS_TAB[i], {16'h0000, wd});
    shadow[i] = wd & MSK[i];
  endtask
  task pulse(input logic [15:0] v);
    @(posedge pclk);
    sdram_byte_wr <= 1'b1;
    sdram_wr_addr <= v;
    @(posedge pclk);
    sdram_byte_wr <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // Expected setups derived from the shadow copy of the registers
  task check_cfg();
    logic sd;
    logic [15:0] dc;
    ebc_area_cfg_t a2, a4;
    ebc_dram_cfg_t d;
    dc = shadow[6];
    sd = dc[15] & dc[14];
    a4 = {shadow[0][12], shadow[1][2:0], shadow[4][4], shadow[5][12]};
    a2 = {shadow[0][10], sd ? 3'h0 : shadow[2][10:8], shadow[4][2],
          shadow[5][10]};
    d = {dc[15], sd, dc[15] & ~dc[14] & dc[11], sd & dc[11],
         dc[15] & dc[7], {1'b0, shadow[7][13:12]} + 3'h1,
         shadow[7][9:8], sd ? {1'b0, shadow[2][9:8]} + 3'h1 : 3'h0,
         sd & shadow[8][15]};
    chk(32'(area4_cfg), 32'(a4));
    chk(32'(area2_cfg), 32'(a2));
    chk(32'(dram_cfg), 32'(d));
    chk(32'({idle_insert_field, idle_insert_en}),
        32'({shadow[3][15:12], shadow[3][15:12] != 4'h0}));
  endtask
  task stop_test();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ***************************************************
  // Sequence
  // ***************************************************
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    stop_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, sdram_byte_wr} = 5'h00;
    {paddr, pwdata, sdram_wr_addr} = 80'h0;
    shadow = '{default: 16'h0000};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Area 2 byte-control select kept 0 while DRAM is on
    foreach (ROWS[r]) begin
      reg_wr(ROWS[r].idx, ROWS[r].wd);
      apb(1'b0, OFS_TAB[ROWS[r].idx], 32'h0);
      #1;
      chk(rd_data, {16'h0000, shadow[ROWS[r].idx]});
      check_cfg();
    end
    $display("register rows done");
    // Unmapped place refuses both directions
    apb(1'b1, 24'hfffd8c, 32'hffffffff);
    chk(32'(rd_err), 32'h1);
    apb(1'b0, 24'hfffd8c, 32'h0);
    #1;
    chk({rd_data[31:1], rd_err}, 32'h1);
    check_cfg();
    $display("unmapped access done");
    pulse(16'h0230);
    chk(32'(mrs_cnt), 32'h0);
    reg_wr(8, 16'h8000);
    repeat (2) @(posedge pclk);
    pulse(16'h0230);
    chk({mode_q, 8'h00, mrs_cnt}, 32'h02300001);
    pulse(16'h0031);
    chk(32'(mrs_cnt), 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd_data[0]), 32'h1);
    reg_wr(8, 16'h0000);
    reg_wr(8, 16'h8000);
    repeat (2) @(posedge pclk);
    pulse(16'h0031);
    chk({mode_q, 8'h00, mrs_cnt}, 32'h00310002);
    $display("mode register setting done");
    // Second reset mid-run clears everything at once
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    chk(32'({dram_cfg, area2_cfg, mrs_cmd}), 32'h0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    shadow = '{default: 16'h0000};
    for (int i = 0; i < NUM_REGS; i++) begin
      apb(1'b0, OFS_TAB[i], 32'h0);
      chk(rd_data, 32'h0);
    end
    #1;
    check_cfg();
    $display("reset values done");
    stop_test();
  end
endmodule
`default_nettype wire
